// ==== verilog/charger_status_pkg.sv ====
package charger_status_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_CUR_LIMIT_HI = 8'h19;
	localparam logic [7:0] OFS_CUR_LIMIT_LO = 8'h1a;
	localparam logic [7:0] OFS_STATUS_FIRST = 8'h1b;
	localparam logic [7:0] OFS_STATUS_SECOND = 8'h1c;

	// ==========================================================
	// Reset values
	localparam logic [15:0] RST_CUR_LIMIT     = 16'h0000;
	localparam logic [7:0]  RST_STATUS_FIRST  = 8'h00;
	localparam logic [7:0]  RST_STATUS_SECOND = 8'h00;

	// ==========================================================
	// Field layout
	localparam int CUR_LIMIT_W     = 9;
	localparam int POS_INPUT_CUR   = 7;
	localparam int POS_INPUT_VOLT  = 6;
	localparam int POS_WATCHDOG    = 5;
	localparam int POS_WEAK_SRC    = 4;
	localparam int POS_POWER_GOOD  = 3;
	localparam int POS_SECOND_IN   = 2;
	localparam int POS_FIRST_IN    = 1;
	localparam int POS_BUS_IN      = 0;
	localparam int POS_PHASE_LSB   = 5;
	localparam int POS_ADAPTER_LSB = 1;
	localparam int POS_DETECT_DONE = 0;

	// ==========================================================
	// Current limit scale: 10 mA per step, 100 mA floor
	localparam int          CUR_STEP_MA     = 10;
	localparam int          CUR_MIN_MA      = 100;
	localparam logic [8:0]  CUR_MIN_CODE    = 9'(CUR_MIN_MA / CUR_STEP_MA);

	// ==========================================================
	// Charge phase codes
	typedef enum logic [2:0] {
		PHASE_IDLE     = 3'h0,
		PHASE_TRICKLE  = 3'h1,
		PHASE_PRE      = 3'h2,
		PHASE_FAST_CC  = 3'h3,
		PHASE_TAPER_CV = 3'h4,
		PHASE_RSVD     = 3'h5,
		PHASE_TOP_OFF  = 3'h6,
		PHASE_DONE     = 3'h7
	} chargePhase_t;

	// ==========================================================
	// Adapter type codes
	typedef enum logic [3:0] {
		ADP_NONE        = 4'h0,
		ADP_STD_PORT    = 4'h1,
		ADP_CHG_PORT    = 4'h2,
		ADP_DEDICATED   = 4'h3,
		ADP_ADJ_HV      = 4'h4,
		ADP_UNKNOWN     = 4'h5,
		ADP_NONSTANDARD = 4'h6,
		ADP_OTG         = 4'h7,
		ADP_UNQUALIFIED = 4'h8,
		ADP_DIRECT_BUS  = 4'hb
	} adapterType_t;

	// ==========================================================
	// Raw status from analog, detection and charge logic
	typedef struct packed {
		logic [8:0] curLimit;
		logic       curLimitValid;
		logic       otgMode;
		logic       fwdCurrentLoop;
		logic       fwdVoltageLoop;
		logic       otgCurrentLoop;
		logic       otgVoltageLoop;
		logic       watchdogExpired;
		logic       weakSource;
		logic       powerGood;
		logic       secondPresent;
		logic       firstPresent;
		logic       busPresent;
		logic [2:0] chargePhase;
		logic       detectDone;
		logic [3:0] detectedType;
		logic       notQualified;
		logic       directBus;
		logic       otgHotFault;
		logic       otgColdFault;
	} rawStatus_t;

	localparam int RAW_W = $bits(rawStatus_t);

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic       read;
		logic       write;
		logic [7:0] wdata;
	} regReq_t;

endpackage

// ==== verilog/charger_status_registers.sv ====
// What this block does
// R1: Report 9-bit current limit, 10mA steps, clamped low
// R2: Bit7: input or OTG current loop regulating
// R3: Bit6: input or OTG voltage loop regulating
// R4: Bit5: watchdog timer expired
// R5: Bit4: weak adapter detected
// R6: Bit3: input power good
// R7: Bit2: second AC input present
// R8: Bit1: first AC input present
// R9: Bit0: bus input present
// R10: Bits7-5 of second byte: charge phase
// R11: Bits4-1: detected adapter codes 1 to 6
// R12: Adapter 0 none/OTG fault, 7 OTG, 8 unqualified
// R13: Adapter B direct bus; reserved codes never shown
// R14: Bit0: adapter detection complete
// R15: All fields read-only, zero after reset
// R16: Writes change nothing
module charger_status_registers
	import charger_status_pkg::*;
(
	input  wire logic       sys_clk,    // System clock, 100 MHz
	input  wire logic       arst_n,     // Asynchronous reset, active low
	input  wire rawStatus_t rawStatus,  // Unsynchronised status sources
	input  wire regReq_t    regReq,     // Register access request
	output logic [7:0]      regRdata,   // Read data, registered
	output logic            regRdValid, // Read data valid pulse
	output logic            regHit      // Last read addressed a mapped register
);

	// ==========================================================
	// Input synchroniser, three stages
	logic [RAW_W-1:0] syncA_q, syncB_q, syncC_q;
	logic [RAW_W-1:0] syncA_d, syncB_d, syncC_d;
	rawStatus_t       stableRaw_q, stableRaw_d;

	always_comb begin
		syncA_d = rawStatus;
		syncB_d = syncA_q;
		syncC_d = syncB_q;
		stableRaw_d = stableRaw_q;
		for (int i = 0; i < RAW_W; i++) begin
			if (syncB_q[i] == syncC_q[i]) begin
				stableRaw_d[i] = syncC_q[i];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			syncA_q     <= '0;
			syncB_q     <= '0;
			syncC_q     <= '0;
			stableRaw_q <= '0;
		end else begin
			syncA_q     <= syncA_d;
			syncB_q     <= syncB_d;
			syncC_q     <= syncC_d;
			stableRaw_q <= stableRaw_d;
		end
	end

	// ==========================================================
	// Status registers
	logic [15:0] curLimit_q, curLimit_d;
	logic [7:0]  statusFirst_q, statusFirst_d;
	logic [7:0]  statusSecond_q, statusSecond_d;
	chargePhase_t phaseCode;
	adapterType_t adapterCode;

	always_comb begin
		curLimit_d = curLimit_q;
		if (stableRaw_q.curLimitValid) begin
			curLimit_d = 16'h0000;
			if (stableRaw_q.curLimit < CUR_MIN_CODE) begin
				curLimit_d[CUR_LIMIT_W-1:0] = CUR_MIN_CODE; // R1
			end else begin
				curLimit_d[CUR_LIMIT_W-1:0] = stableRaw_q.curLimit; // R1
			end
		end

		statusFirst_d = 8'h00;
		statusFirst_d[POS_INPUT_CUR] = stableRaw_q.otgMode ? stableRaw_q.otgCurrentLoop
			: stableRaw_q.fwdCurrentLoop; // R2
		statusFirst_d[POS_INPUT_VOLT] = stableRaw_q.otgMode ? stableRaw_q.otgVoltageLoop
			: stableRaw_q.fwdVoltageLoop; // R3
		statusFirst_d[POS_WATCHDOG]   = stableRaw_q.watchdogExpired; // R4
		statusFirst_d[POS_WEAK_SRC]   = stableRaw_q.weakSource; // R5
		statusFirst_d[POS_POWER_GOOD] = stableRaw_q.powerGood; // R6
		statusFirst_d[POS_SECOND_IN]  = stableRaw_q.secondPresent; // R7
		statusFirst_d[POS_FIRST_IN]   = stableRaw_q.firstPresent; // R8
		statusFirst_d[POS_BUS_IN]     = stableRaw_q.busPresent; // R9

		// Reserved phase shows as not charging
		phaseCode = chargePhase_t'(stableRaw_q.chargePhase); // R10
		if (phaseCode == PHASE_RSVD) begin
			phaseCode = PHASE_IDLE;
		end

		// Adapter code, highest priority first
		if (stableRaw_q.otgMode && (stableRaw_q.otgHotFault || stableRaw_q.otgColdFault)) begin
			adapterCode = ADP_NONE; // R12
		end else if (stableRaw_q.otgMode) begin
			adapterCode = ADP_OTG; // R12
		end else if (!(stableRaw_q.busPresent || stableRaw_q.firstPresent
				|| stableRaw_q.secondPresent)) begin
			adapterCode = ADP_NONE; // R12
		end else if (stableRaw_q.directBus) begin
			adapterCode = ADP_DIRECT_BUS; // R13
		end else if (stableRaw_q.notQualified) begin
			adapterCode = ADP_UNQUALIFIED; // R12
		end else begin
			case (stableRaw_q.detectedType)
				4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
					adapterCode = adapterType_t'(stableRaw_q.detectedType); // R11
				end
				default: begin
					adapterCode = ADP_NONE; // R13
				end
			endcase
		end

		statusSecond_d = 8'h00;
		statusSecond_d[POS_PHASE_LSB +: 3]   = phaseCode; // R10
		statusSecond_d[POS_ADAPTER_LSB +: 4] = adapterCode; // R11
		statusSecond_d[POS_DETECT_DONE]      = stableRaw_q.detectDone; // R14
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			curLimit_q     <= RST_CUR_LIMIT; // R15
			statusFirst_q  <= RST_STATUS_FIRST; // R15
			statusSecond_q <= RST_STATUS_SECOND; // R15
		end else begin
			curLimit_q     <= curLimit_d;
			statusFirst_q  <= statusFirst_d;
			statusSecond_q <= statusSecond_d;
		end
	end

	// ==========================================================
	// Read port; writes are decoded nowhere
	logic [7:0] rdata_q, rdata_d;
	logic       rdValid_q, rdValid_d;
	logic       hit_q, hit_d;

	always_comb begin
		rdata_d   = rdata_q;
		hit_d     = hit_q;
		rdValid_d = regReq.read; // R16
		if (regReq.read) begin
			hit_d = 1'b1;
			case (regReq.addr)
				OFS_CUR_LIMIT_HI:  rdata_d = curLimit_q[15:8]; // R15
				OFS_CUR_LIMIT_LO:  rdata_d = curLimit_q[7:0];
				OFS_STATUS_FIRST:  rdata_d = statusFirst_q;
				OFS_STATUS_SECOND: rdata_d = statusSecond_q;
				default: begin
					rdata_d = 8'h00;
					hit_d   = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q   <= 8'h00;
			rdValid_q <= 1'b0;
			hit_q     <= 1'b0;
		end else begin
			rdata_q   <= rdata_d;
			rdValid_q <= rdValid_d;
			hit_q     <= hit_d;
		end
	end

	assign regRdata   = rdata_q;
	assign regRdValid = rdValid_q;
	assign regHit     = hit_q;

endmodule

// ==== test/charger_status_sva.sv ====
module charger_status_sva
	import charger_status_pkg::*;
(
	input wire logic       sys_clk,    // Clock
	input wire logic       arst_n,     // Reset
	input wire rawStatus_t rawStatus,  // Sources
	input wire regReq_t    regReq,     // Request
	input wire logic [7:0] regRdata,   // Read data
	input wire logic       regRdValid, // Read valid
	input wire logic       regHit      // Mapped hit
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	logic mapped;
	assign mapped = regReq.addr inside {[8'h19:8'h1c]};
	sequence sRd(a);
		regReq.read && regReq.addr == a;
	endsequence
	// ==========================================================
	// Read port behaviour
	a_read_answer:
		assert property (regReq.read |=> regRdValid) else $error("read unanswered");
	a_valid_cause:
		assert property (regRdValid |-> $past(regReq.read)) else $error("stray valid");
	a_mapped_hit:
		assert property (regReq.read && mapped |=> regHit) else $error("mapped miss");
	a_unmapped_zero:
		assert property (regReq.read && !mapped |=> !regHit && regRdata == 8'h00)
			else $error("unmapped data");
	a_data_holds:
		assert property (!regReq.read |=> $stable(regRdata) && $stable(regHit))
			else $error("data moved");
	// ==========================================================
	// Field contents
	a_upper_reserved:
		assert property (sRd(8'h19) |=> regRdata[7:1] == 7'h00) else $error("reserved set");
	a_phase_legal:
		assert property (sRd(8'h1c) |=> regRdata[7:5] != 3'h5) else $error("phase 5");
	a_adapter_legal:
		assert property (sRd(8'h1c) |=> !(regRdata[4:1] inside {4'h9, 4'ha, [4'hc:4'hf]}))
			else $error("adapter reserved");
	a_good_track:
		assert property (rawStatus.powerGood [*7] ##0 sRd(8'h1b) |=> regRdata[3])
			else $error("power good lost");
endmodule

// ==== test/status_source.sv ====
module status_source
	import charger_status_pkg::*;
(
	input  wire logic       sys_clk,  // Clock
	input  wire rawStatus_t want,     // Levels asked for
	output rawStatus_t      rawStatus // Levels at the block
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Analog and detection levels settle a cycle late
	always_ff @(posedge sys_clk) begin
		rawStatus <= want;
	end
endmodule

// ==== test/tb_top.sv ====
`define CHK(got, exp) begin \
	samplesChecked++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("ERROR %0t: got %h expected %h", $time, got, exp); \
	end \
end
module tb_top
	import charger_status_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk;
	logic        arst_n;
	rawStatus_t  want;
	rawStatus_t  rawStatus;
	regReq_t     regReq;
	logic [7:0]  regRdata;
	logic        regRdValid;
	logic        regHit;
	rawStatus_t  r;
	int          cyc = 0;
	int          mismatches = 0;
	int          samplesChecked = 0;
	logic [32:0] adpIn [6] = '{33'h1004, 33'h1008, 33'h400000, 33'h400002, 33'h400001, 33'h30};
	logic [3:0]  adpExp [6] = '{4'hb, 4'h8, 4'h7, 4'h0, 4'h0, 4'h0};
	status_source src (.sys_clk(sys_clk), .want(want), .rawStatus(rawStatus));
	charger_status_registers uut (.sys_clk(sys_clk), .arst_n(arst_n), .rawStatus(rawStatus),
		.regReq(regReq), .regRdata(regRdata), .regRdValid(regRdValid), .regHit(regHit));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			test_done();
		end
	end
	// ==========================================================
	// Access, status and end-of-run tasks
	task automatic test_done();
		$display("Checked %0d, mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
		regReq.addr <= a;
		regReq.read <= 1'b1;
		@(posedge sys_clk);
		regReq.read <= 1'b0;
		#1;
		`CHK(regRdValid, 1'b1)
		`CHK(regRdata, e)
		`CHK(regHit, h)
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a);
		regReq.addr <= a;
		regReq.wdata <= 8'hff;
		regReq.write <= 1'b1;
		@(posedge sys_clk);
		regReq.write <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic st(input rawStatus_t v);
		want <= v;
		repeat (8) @(posedge sys_clk);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		arst_n = 1'b0;
		want = '0;
		regReq = '0;
		repeat (10) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		for (int a = 8'h19; a <= 8'h1c; a++) rd(8'(a), 8'h00, 1'b1);
		for (int i = 0; i < 10; i++) begin
			r = '0;
			r[(i < 6) ? 12 + i : (i < 8) ? 14 + i : 10 + i] = 1'b1;
			r.otgMode = (i > 7);
			st(r);
			rd(OFS_STATUS_FIRST, 8'h01 << ((i < 8) ? i : i - 2), 1'b1);
		end
		r = '0;
		r.otgMode = 1'b1;
		r.fwdCurrentLoop = 1'b1;
		st(r);
		rd(OFS_STATUS_FIRST, 8'h00, 1'b1);
		for (int p = 0; p < 8; p++) begin
			r = '0;
			r.chargePhase = 3'(p);
			st(r);
			rd(OFS_STATUS_SECOND, {(p == 5) ? 3'h0 : 3'(p), 5'h00}, 1'b1);
		end
		for (int t = 0; t < 16; t++) begin
			r = '0;
			r.busPresent = 1'b1;
			r.detectDone = 1'b1;
			r.detectedType = 4'(t);
			st(r);
			rd(OFS_STATUS_SECOND, {3'h0, (t > 0 && t < 7) ? 4'(t) : 4'h0, 1'b1}, 1'b1);
		end
		for (int k = 0; k < 6; k++) begin
			st(rawStatus_t'(adpIn[k]));
			rd(OFS_STATUS_SECOND, {3'h0, adpExp[k], 1'b0}, 1'b1);
		end
		r = '0;
		r.curLimitValid = 1'b1;
		r.curLimit = 9'h14a;
		st(r);
		rd(OFS_CUR_LIMIT_HI, 8'h01, 1'b1);
		rd(OFS_CUR_LIMIT_LO, 8'h4a, 1'b1);
		r.curLimit = 9'h005;
		st(r);
		rd(OFS_CUR_LIMIT_LO, 8'h0a, 1'b1);
		r.curLimitValid = 1'b0;
		r.curLimit = 9'h1ff;
		r.powerGood = 1'b1;
		st(r);
		rd(OFS_CUR_LIMIT_HI, 8'h00, 1'b1);
		for (int a = 8'h19; a <= 8'h1c; a++) wr(8'(a));
		rd(OFS_CUR_LIMIT_LO, 8'h0a, 1'b1);
		rd(OFS_STATUS_FIRST, 8'h08, 1'b1);
		rd(8'h20, 8'h00, 1'b0);
		test_done();
	end
endmodule
bind charger_status_registers charger_status_sva chk (.sys_clk(sys_clk), .arst_n(arst_n),
	.rawStatus(rawStatus), .regReq(regReq), .regRdata(regRdata), .regRdValid(regRdValid),
	.regHit(regHit));
